// ### hw/wwdt_pkg.sv
// wwdt_pkg: constants, register map and field layout of the windowed watchdog
// assumes a 100 MHz system clock and a 32-bit APB register bus

`default_nettype none

package wwdt_pkg;

   // system clock and low-power rc oscillator timing
   localparam int unsigned CLK_PERIOD_PS    = 10000;       // 100 MHz
   localparam int unsigned RCOSC_FREQ_KHZ   = 32;          // nominal watchdog clock
   localparam int unsigned RCOSC_PERIOD_PS  = 1000000000 / RCOSC_FREQ_KHZ;
   localparam int unsigned RCOSC_CYCLES     = RCOSC_PERIOD_PS / CLK_PERIOD_PS;

   // prescaler ratios and nominal prescaler output periods
   localparam int unsigned PRE_DIV_SHORT    = 32;          // 5-bit mode
   localparam int unsigned PRE_DIV_LONG     = 128;         // 7-bit mode
   localparam int unsigned PRE_PERIOD_SHORT_US = 1000;     // 1 ms
   localparam int unsigned PRE_PERIOD_LONG_US  = 4000;     // 4 ms
   localparam int unsigned PRE_WIDTH        = 7;
   localparam int unsigned POST_WIDTH       = 15;          // counts 0 to 32,767
   localparam int unsigned POST_SETTINGS    = 16;

   // window: a clear is legal only in the last WIN_NUM/WIN_DEN of the period
   localparam int unsigned WIN_NUM          = 1;
   localparam int unsigned WIN_DEN          = 4;

   // apb register byte offsets
   localparam logic [7:0]  OFS_RESET_CTRL   = 8'h00;       // reset_control_reg
   localparam logic [7:0]  OFS_FUSE_WORD    = 8'h04;       // watchdog_fuse_word
   localparam logic [7:0]  OFS_STATUS       = 8'h08;       // live counter view

   // reset_control_reg field positions
   localparam int unsigned BIT_IDLE         = 2;
   localparam int unsigned BIT_SLEEP        = 3;
   localparam int unsigned BIT_TIMEOUT      = 4;
   localparam int unsigned BIT_SOFT_EN      = 5;

   // status register field positions
   localparam int unsigned BIT_STAT_RUN     = 16;
   localparam int unsigned BIT_STAT_WIN     = 17;

   // watchdog_fuse_word layout
   typedef struct packed {
      logic       fuse_enable;       // bit 7: watchdog always on
      logic       window_disable;    // bit 6: 1 = non-window mode
      logic       reserved;          // bit 5
      logic       prescale_select;   // bit 4: 1 = divide by 128
      logic [3:0] postscale_select;  // bits 3..0: ratio 1:2^n
   } wwdt_fuse_t;

   localparam logic [7:0]  FUSE_RESET       = 8'hdf;

   // power-save state of the device as seen by the watchdog
   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_SLEEP,
      PWR_IDLE
   } wwdt_pwr_t;

endpackage

`default_nettype wire

// ### hw/wwdt_low_power_rc_osc_osc.sv
// wwdt_rc_osc: stand-in for the low-power rc oscillator, one tick per period
// assumes the 100 MHz system clock; the tick stays low while the oscillator is off

`timescale 1ns/1ps
`default_nettype none

module wwdt_rc_osc
   import wwdt_pkg::*;
#(
   parameter int unsigned PERIOD_CYCLES = RCOSC_CYCLES
)(
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic osc_on,
   output logic      rc_tick
);

   logic [12:0] phase;

   // free count while switched on, parked at zero while off
   always_ff @(posedge clk)
   begin
      if (sys_rst || !osc_on)
         phase <= 13'h0000;
      else if (phase == 13'(PERIOD_CYCLES - 1))
         phase <= 13'h0000;
      else
         phase <= phase + 13'h0001;
   end

   assign rc_tick = osc_on && (phase == 13'(PERIOD_CYCLES - 1));

endmodule // wwdt_rc_osc

`default_nettype wire

// ### hw/wwdt_divider.sv
// wwdt_divider: clearable modulo counter used as prescaler and postscaler
// assumes tick and clear are on the same clock; clear wins over tick

`timescale 1ns/1ps
`default_nettype none

module wwdt_divider #(
   parameter int unsigned WIDTH = 7
)(
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             clear,
   input  wire logic             tick,
   input  wire logic [WIDTH-1:0] limit,
   output logic      [WIDTH-1:0] count,
   output logic                  wrap
);

   // wrap marks the tick that leaves the terminal count
   assign wrap = tick && (count == limit);

   // count ticks, return to zero after the limit or on clear
   always_ff @(posedge clk)
   begin
      if (sys_rst || clear)
         count <= '0;
      else if (wrap)
         count <= '0;
      else if (tick)
         count <= count + WIDTH'(1);
   end

endmodule // wwdt_divider

`default_nettype wire

// ### hw/wwdt_core.sv
// wwdt_core: windowed watchdog with apb registers, pre/postscaler and power-save hooks
// assumes cpu event pulses are one cycle on clk; por_rst clears the sticky flags
// Operation
// - counter ticks from low-power rc oscillator; enabling watchdog turns oscillator on
// - prescaler divides by 32 or 128 per prescale-select bit
// - at 32 kHz prescaler output period is 1 ms or 4 ms
// - postscaler divides by 1 to 32768, 16 settings, fuse bits 3..0
// - all counts cleared on device reset and clock switch completion
// - all counts cleared on power-save entry and on return to run
// - clear instruction in normal run clears counter, prescaler and postscaler
// - watchdog keeps counting in sleep/idle; timeout wakes the device
// - timeout flag at bit 4 set by hardware, cleared only by software; the code also clears it on por_rst
// - fuse enable set runs watchdog always; soft enable ignored
// - fuse enable clear: watchdog runs only while soft enable bit 5 set
// - soft enable bit cleared by every device reset
// - window mode: clear before last quarter of period causes watchdog reset
// - prescale-select 1 means divide by 128, 0 divide by 32
// - window-disable 1 selects normal mode, 0 window mode
//
// Added by the designer: the placing of the registers and the APB register port.

`timescale 1ns/1ps
`default_nettype none

module wwdt_core
   import wwdt_pkg::*;
#(
   parameter int unsigned OSC_PERIOD  = RCOSC_CYCLES,
   parameter logic [7:0]  FUSE_INIT   = FUSE_RESET
)(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        por_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        watchdog_clear_instr,
   input  wire logic        power_save_instr,
   input  wire logic        power_save_idle,
   input  wire logic        wake_exit,
   input  wire logic        clk_switch_done,
   output logic             low_power_rc_osc_on,
   output logic             watchdog_reset_req,
   output logic             watchdog_wake
);

   // prescale ratio minus one for the selected mode
   function automatic logic [PRE_WIDTH-1:0] pre_limit(input logic long_mode);
      pre_limit = long_mode ? PRE_WIDTH'(PRE_DIV_LONG - 1) : PRE_WIDTH'(PRE_DIV_SHORT - 1);
   endfunction

   // postscale ratio minus one for a 4-bit setting
   function automatic logic [POST_WIDTH-1:0] post_limit(input logic [3:0] sel);
      logic [POST_WIDTH:0] ratio;
      ratio = (POST_WIDTH + 1)'(1) << sel;
      post_limit = POST_WIDTH'(ratio - (POST_WIDTH + 1)'(1));
   endfunction

   wwdt_fuse_t              fuse;
   logic                    soft_enable;
   logic                    timeout_flag;
   logic                    sleep_flag;
   logic                    idle_flag;
   wwdt_pwr_t               pwr_state;
   logic                    wd_enabled;
   logic                    rc_tick;
   logic                    cnt_clear;
   logic [PRE_WIDTH-1:0]    pre_cnt;
   logic                    pre_wrap;
   logic [POST_WIDTH-1:0]   post_cnt;
   logic                    post_wrap;
   logic                    timeout;
   logic                    in_run;
   logic                    clear_ok;
   logic                    clear_early;
   logic [31:0]             elapsed;
   logic [31:0]             total;
   logic                    apb_wr;
   logic                    wr_ctrl;
   logic                    wr_fuse;
   logic                    addr_ok;

   // fuse or soft bit enables; oscillator follows the enable
   assign wd_enabled          = fuse.fuse_enable || soft_enable;
   assign low_power_rc_osc_on = wd_enabled;
   assign in_run              = (pwr_state == PWR_RUN);

   // watchdog clock source
   wwdt_rc_osc #(
      .PERIOD_CYCLES (OSC_PERIOD)
   ) u_osc (
      .clk     (clk),
      .sys_rst (sys_rst),
      .osc_on  (wd_enabled),
      .rc_tick (rc_tick)
   );

   // prescaler: 32 or 128 oscillator ticks per output
   wwdt_divider #(
      .WIDTH (PRE_WIDTH)
   ) u_pre (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clear   (cnt_clear),
      .tick    (rc_tick),
      .limit   (pre_limit(fuse.prescale_select)),
      .count   (pre_cnt),
      .wrap    (pre_wrap)
   );

   // postscaler: one step per prescaler output
   wwdt_divider #(
      .WIDTH (POST_WIDTH)
   ) u_post (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clear   (cnt_clear),
      .tick    (pre_wrap),
      .limit   (post_limit(fuse.postscale_select)),
      .count   (post_cnt),
      .wrap    (post_wrap)
   );

   // timeout when the postscaler leaves its selected ratio
   assign timeout = wd_enabled && post_wrap;

   // window check: elapsed oscillator ticks against the whole period
   always_comb
   begin
      elapsed = 32'(post_cnt) * (fuse.prescale_select ? 32'(PRE_DIV_LONG) : 32'(PRE_DIV_SHORT))
              + 32'(pre_cnt);
      total   = (32'(post_limit(fuse.postscale_select)) + 32'h0000_0001)
              * (fuse.prescale_select ? 32'(PRE_DIV_LONG) : 32'(PRE_DIV_SHORT));
      clear_early = !fuse.window_disable
                  && (elapsed * 32'(WIN_DEN) < total * 32'(WIN_DEN - WIN_NUM));
   end

   assign clear_ok = watchdog_clear_instr && in_run && wd_enabled;

   // every cause that zeroes counter, prescaler and postscaler
   assign cnt_clear = !wd_enabled
                    || clk_switch_done
                    || watchdog_reset_req
                    || (in_run && power_save_instr)
                    || (!in_run && (wake_exit || timeout))
                    || (in_run && watchdog_clear_instr);

   // power-save state tracking
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         pwr_state <= PWR_RUN;
      else
      begin
         unique case (pwr_state)
            PWR_RUN:
               if (power_save_instr)
                  pwr_state <= power_save_idle ? PWR_IDLE : PWR_SLEEP;
            PWR_SLEEP,
            PWR_IDLE:
               if (timeout || wake_exit)
                  pwr_state <= PWR_RUN;
            default:
               pwr_state <= PWR_RUN;
         endcase
      end
   end

   // device reset on run-time timeout or early clear in window mode
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         watchdog_reset_req <= 1'b0;
      else
         watchdog_reset_req <= (in_run && timeout) || (clear_ok && clear_early);
   end

   // wake pulse on timeout during sleep or idle
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         watchdog_wake <= 1'b0;
      else
         watchdog_wake <= !in_run && timeout;
   end

   // apb decode: zero wait states, error on unmapped address
   assign apb_wr  = psel && penable && pwrite;
   assign addr_ok = (paddr == OFS_RESET_CTRL) || (paddr == OFS_FUSE_WORD)
                 || (paddr == OFS_STATUS);
   assign wr_ctrl = apb_wr && (paddr == OFS_RESET_CTRL);
   assign wr_fuse = apb_wr && (paddr == OFS_FUSE_WORD);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !addr_ok;

   // soft enable, cleared by every device reset
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         soft_enable <= 1'b0;
      else if (wr_ctrl)
         soft_enable <= pwdata[BIT_SOFT_EN];
   end

   // fuse word image
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         fuse <= wwdt_fuse_t'(FUSE_INIT);
      else if (wr_fuse)
         fuse <= wwdt_fuse_t'(pwdata[7:0]);
   end

   // sticky timeout flag: hardware set wins, software writes 0 to clear
   always_ff @(posedge clk)
   begin
      if (por_rst)
         timeout_flag <= 1'b0;
      else if (timeout || (clear_ok && clear_early))
         timeout_flag <= 1'b1;
      else if (wr_ctrl && !pwdata[BIT_TIMEOUT])
         timeout_flag <= 1'b0;
   end

   // sleep and idle status, left for software to clear after wake
   always_ff @(posedge clk)
   begin
      if (por_rst)
      begin
         sleep_flag <= 1'b0;
         idle_flag  <= 1'b0;
      end
      else
      begin
         if (in_run && power_save_instr && !power_save_idle)
            sleep_flag <= 1'b1;
         else if (wr_ctrl && !pwdata[BIT_SLEEP])
            sleep_flag <= 1'b0;
         if (in_run && power_save_instr && power_save_idle)
            idle_flag <= 1'b1;
         else if (wr_ctrl && !pwdata[BIT_IDLE])
            idle_flag <= 1'b0;
      end
   end

   // registered read data
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            OFS_RESET_CTRL:
            begin
               prdata[BIT_SOFT_EN] <= soft_enable;
               prdata[BIT_TIMEOUT] <= timeout_flag;
               prdata[BIT_SLEEP]   <= sleep_flag;
               prdata[BIT_IDLE]    <= idle_flag;
            end
            OFS_FUSE_WORD:
               prdata[7:0] <= fuse;
            OFS_STATUS:
            begin
               prdata[POST_WIDTH-1:0] <= post_cnt;
               prdata[BIT_STAT_RUN]   <= wd_enabled;
               prdata[BIT_STAT_WIN]   <= !clear_early;
            end
            default:
               prdata <= 32'h0000_0000;
         endcase
      end
   end

   // checks on the running design
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_osc_follows_enable: assert property (fuse.fuse_enable |-> low_power_rc_osc_on)
      else $error("oscillator off while fuse enable set");
   a_fuse_forces_run: assert property (fuse.fuse_enable && !soft_enable |-> wd_enabled)
      else $error("fuse enable did not force watchdog on");
   a_soft_gates_run: assert property (!fuse.fuse_enable && !soft_enable |-> !rc_tick)
      else $error("watchdog ticking while disabled");
   a_prescale_ratio: assert property (pre_wrap |-> pre_cnt == (fuse.prescale_select ? 7'h7f : 7'h1f))
      else $error("prescaler wrapped at wrong count");
   a_clear_instr: assert property (in_run && watchdog_clear_instr && !clk_switch_done |=> pre_cnt == 7'h00 && post_cnt == 15'h0000)
      else $error("clear instruction left counts");
   a_switch_clears: assert property (clk_switch_done |=> pre_cnt == 7'h00 && post_cnt == 15'h0000)
      else $error("clock switch left counts");
   a_power_save_instr_entry: assert property (in_run && power_save_instr |=> !in_run && post_cnt == 15'h0000)
      else $error("power-save entry not handled");
   a_sleep_wakeup: assert property (!in_run && timeout |=> watchdog_wake && in_run && timeout_flag)
      else $error("timeout in sleep did not wake");
   a_run_timeout_reset: assert property (in_run && timeout |=> watchdog_reset_req ##1 !watchdog_reset_req)
      else $error("run timeout did not pulse reset");
   a_flag_sticky: assert property (timeout_flag && !wr_ctrl && !por_rst |=> timeout_flag)
      else $error("timeout flag cleared by itself");
   a_window_early: assert property (clear_ok && clear_early |=> watchdog_reset_req && timeout_flag)
      else $error("early clear in window mode not punished");
   a_soft_reset_clear: assert property (disable iff (1'b0) sys_rst |=> !soft_enable)
      else $error("soft enable survived reset");

   c_run_timeout: cover property (in_run && timeout);
   c_sleep_wake: cover property (!in_run && timeout);
   c_window_violation: cover property (clear_ok && clear_early);
   c_window_clear_ok: cover property (clear_ok && !clear_early && !fuse.window_disable);

endmodule // wwdt_core

`default_nettype wire

// ### sim/test_windowed_watchdog_timer.sv
// test_windowed_watchdog_timer: self-checking bench for the windowed watchdog core
// assumes wwdt_core with a 4-cycle oscillator stand-in and a zero-wait apb slave

`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) \
   begin \
      comparisons++; \
      if ((got) !== (ex)) \
      begin \
         fail_count++; \
         $display("[ERR] %s expected %h seen %h", nm, ex, got); \
      end \
   end

module test_windowed_watchdog_timer
   import wwdt_pkg::*;
;
   localparam int unsigned OSC  = 4;          // shortened oscillator period
   localparam int          BASE = 32 * OSC;   // divide by 32, ratio 1:1, in clocks

   typedef struct packed {
      logic        wr;
      logic [7:0]  a;
      logic [31:0] d;
      logic [31:0] ex;
      logic [31:0] m;
      logic        er;
   } wwdt_row_t;

   logic        clk, sys_rst, por_rst, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, er, rq, wk;
   logic        watchdog_clear_instr, power_save_instr, power_save_idle;
   logic        wake_exit, clk_switch_done;
   logic        low_power_rc_osc_on, watchdog_reset_req, watchdog_wake;
   int          fail_count, comparisons, n;

   // register rows: fuse off and soft enable, status view, unmapped address
   wwdt_row_t   rows[9] = '{
      '{1'b1, OFS_FUSE_WORD,  32'h40, 32'h0,     32'h0,        1'b0},
      '{1'b0, OFS_FUSE_WORD,  32'h0,  32'h40,    32'hff,       1'b0},
      '{1'b1, OFS_RESET_CTRL, 32'h20, 32'h0,     32'h0,        1'b0},
      '{1'b0, OFS_RESET_CTRL, 32'h0,  32'h20,    32'hffffffff, 1'b0},
      '{1'b0, OFS_STATUS,     32'h0,  32'h10000, 32'h10000,    1'b0},
      '{1'b1, OFS_RESET_CTRL, 32'h0,  32'h0,     32'h0,        1'b0},
      '{1'b0, OFS_STATUS,     32'h0,  32'h0,     32'h17fff,    1'b0},
      '{1'b1, 8'h0c,          32'h1,  32'h0,     32'h0,        1'b1},
      '{1'b0, 8'h0c,          32'h0,  32'h0,     32'hffffffff, 1'b1}};
   logic [7:0]  pf[4] = '{8'hc0, 8'hc1, 8'hc2, 8'hd0};
   int          pe[4] = '{BASE, 2 * BASE, 4 * BASE, 4 * BASE};

   wwdt_core #(.OSC_PERIOD(OSC)) i_wwdt_core (
      .clk(clk), .sys_rst(sys_rst), .por_rst(por_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .watchdog_clear_instr(watchdog_clear_instr), .power_save_instr(power_save_instr),
      .power_save_idle(power_save_idle), .wake_exit(wake_exit),
      .clk_switch_done(clk_switch_done), .low_power_rc_osc_on(low_power_rc_osc_on),
      .watchdog_reset_req(watchdog_reset_req), .watchdog_wake(watchdog_wake));

   // 100 MHz clock
   initial clk = 1'b0;
   always #5 clk = ~clk;

   // verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // one apb transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1)
      begin
         fail_count++;
         $display("[ERR] pready expected 1 seen %b", pready);
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      `CHK(nm, ex, rd)
   endtask

   // one-cycle event: 0 clear, 1 clock switch, 2 power save, 3 wake exit
   task automatic pulse(input int s);
      @(posedge clk);
      case (s)
         0: watchdog_clear_instr <= 1'b1;
         1: clk_switch_done <= 1'b1;
         2: power_save_instr <= 1'b1;
         default: wake_exit <= 1'b1;
      endcase
      @(posedge clk);
      watchdog_clear_instr <= 1'b0;
      clk_switch_done      <= 1'b0;
      power_save_instr     <= 1'b0;
      wake_exit            <= 1'b0;
   endtask

   task automatic idle(input int c);
      repeat (c) @(posedge clk);
   endtask

   // count cycles until a reset request or wake pulse, bounded
   task automatic wait_evt(input int lim, input bit must);
      n  = 0;
      rq = 1'b0;
      wk = 1'b0;
      while (n < lim && rq !== 1'b1 && wk !== 1'b1)
      begin
         @(negedge clk);
         n++;
         rq = watchdog_reset_req;
         wk = watchdog_wake;
      end
      if (must && rq !== 1'b1 && wk !== 1'b1)
      begin
         fail_count++;
         $display("[ERR] event expected pulse seen none");
         close_out();
      end
   endtask

   function automatic bit near(input int e);
      return (n >= e - 8) && (n <= e + 8);
   endfunction

   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask

   // main sequence
   initial
   begin
      {sys_rst, por_rst} = 2'b11;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {watchdog_clear_instr, power_save_instr, power_save_idle} = 3'b000;
      {wake_exit, clk_switch_done} = 2'b00;
      fail_count = 0;
      comparisons = 0;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      por_rst <= 1'b0;
      @(negedge clk);
      `CHK("osc at reset", 1'b1, low_power_rc_osc_on)
      rdchk("fuse at reset", OFS_FUSE_WORD, 32'hdf);
      rdchk("ctrl at reset", OFS_RESET_CTRL, 32'h0);
      done("reset");
      foreach (rows[i])
      begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         `CHK("table data", rows[i].ex, rd & rows[i].m)
         `CHK("table error", rows[i].er, er)
      end
      @(negedge clk);
      `CHK("osc disabled", 1'b0, low_power_rc_osc_on)
      done("registers");
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b1, OFS_FUSE_WORD, {24'h0, pf[i]});
         pulse(1);
         wait_evt(5000, 1'b1);
         `CHK("period", 1'b1, near(pe[i]))
         `CHK("reset request", 1'b1, rq)
         @(negedge clk);
         `CHK("request width", 1'b0, watchdog_reset_req)
         rdchk("flag set", OFS_RESET_CTRL, 32'h10);
         apb(1'b1, OFS_RESET_CTRL, 32'h10);
         rdchk("flag kept", OFS_RESET_CTRL, 32'h10);
         apb(1'b1, OFS_RESET_CTRL, 32'h0);
         rdchk("flag cleared", OFS_RESET_CTRL, 32'h0);
      end
      done("periods");
      apb(1'b1, OFS_FUSE_WORD, 32'hc0);
      for (int k = 0; k < 2; k++)
      begin
         pulse(1);
         idle(100);
         pulse(k);
         wait_evt(1000, 1'b1);
         `CHK("restart", 1'b1, near(BASE))
         apb(1'b1, OFS_RESET_CTRL, 32'h0);
      end
      done("restart");
      for (int k = 0; k < 2; k++)
      begin
         power_save_idle <= k[0];
         idle(60);
         pulse(2);
         wait_evt(1000, 1'b1);
         `CHK("wake pulse", 1'b1, wk)
         `CHK("no reset asleep", 1'b0, rq)
         `CHK("entry restart", 1'b1, near(BASE))
         rdchk("power flags", OFS_RESET_CTRL, k ? 32'h14 : 32'h18);
         apb(1'b1, OFS_RESET_CTRL, 32'h0);
         rdchk("power cleared", OFS_RESET_CTRL, 32'h0);
      end
      pulse(2);
      idle(100);
      pulse(3);
      wait_evt(1000, 1'b1);
      `CHK("exit restart", 1'b1, near(BASE))
      `CHK("run reset", 1'b1, rq)
      apb(1'b1, OFS_RESET_CTRL, 32'h0);
      done("power save");
      apb(1'b1, OFS_FUSE_WORD, 32'h80);
      pulse(1);
      idle(40);
      rdchk("window early", OFS_STATUS, 32'h10000);
      pulse(0);
      wait_evt(4, 1'b1);
      `CHK("early clear", 1'b1, rq)
      rdchk("early flag", OFS_RESET_CTRL, 32'h10);
      apb(1'b1, OFS_RESET_CTRL, 32'h0);
      pulse(1);
      idle(110);
      rdchk("window late", OFS_STATUS, 32'h30000);
      pulse(0);
      wait_evt(1000, 1'b1);
      `CHK("late clear", 1'b1, near(BASE))
      apb(1'b1, OFS_RESET_CTRL, 32'h0);
      done("window");
      apb(1'b1, OFS_FUSE_WORD, 32'h40);
      wait_evt(400, 1'b0);
      `CHK("soft off", 1'b0, rq | wk)
      `CHK("osc soft off", 1'b0, low_power_rc_osc_on)
      apb(1'b1, OFS_RESET_CTRL, 32'h20);
      @(negedge clk);
      `CHK("osc soft on", 1'b1, low_power_rc_osc_on)
      pulse(1);
      wait_evt(1000, 1'b1);
      `CHK("soft run", 1'b1, near(BASE))
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      rdchk("soft after reset", OFS_RESET_CTRL, 32'h10);
      rdchk("fuse after reset", OFS_FUSE_WORD, 32'hdf);
      done("soft enable");
      close_out();
   end

endmodule // test_windowed_watchdog_timer

`default_nettype wire
